// [rtl/ipb_bank.sv]
// ipb_bank: APB register bank for the enable/priority pairs of request
// groups two and three, plus the shared source select.
// assumes a single clock and requests already latched elsewhere.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module ipb_bank #(
  parameter int G2_W = 8,
  parameter int G3_W = 8
) (
  // clock and reset
  input  wire logic                 CORE_CLK,
  input  wire logic                 RST,
  // apb slave
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [13:0]          PADDR,
  input  wire logic [31:0]          PWDATA,
  input  wire logic [3:0]           PSTRB,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  // group two request sources
  input  wire logic                 PIN7_REQ,
  input  wire logic                 LOW_VOLTAGE_DETECTOR_REQ,
  input  wire logic                 PIN6_REQ,
  input  wire logic                 CMP0_REQ,
  input  wire logic                 PIN5_REQ,
  input  wire logic                 CMP1_REQ,
  input  wire logic [4:1]           PORTA_SHARED_REQ,
  input  wire logic [4:1]           PORTD_SHARED_REQ,
  input  wire logic                 PIN0_REQ,
  // group three request sources
  input  wire logic                 TIMER_A_REQ,
  input  wire logic                 MULTICHAN_TIMER_REQ,
  input  wire logic [3:0]           PORTC_REQ,
  // to arbiter
  output logic      [2*G2_W-1:0]    REQUEST_GROUP_TWO_LEVEL,
  output logic      [2*G3_W-1:0]    REQUEST_GROUP_THREE_LEVEL,
  output logic      [G2_W-1:0]      REQUEST_GROUP_TWO,
  output logic      [G3_W-1:0]      REQUEST_GROUP_THREE
);

  ipb_pkg::ipb_apb_req_s   req;
  ipb_pkg::ipb_enable_pair_s g2_r;
  ipb_pkg::ipb_enable_pair_s g3_r;
  logic [7:0]              shared_source_select_r;
  logic [G2_W-1:0]         g2_raw;
  logic [G3_W-1:0]         g3_raw;
  logic                    wr_take;
  logic                    rd_take;
  logic                    addr_ok;
  logic [7:0]              rd_byte;
  logic                    wr_g2_high;
  logic                    wr_g2_low;
  logic                    wr_g3_high;
  logic                    wr_g3_low;
  logic                    wr_sel;
  logic [3:0]              g2_enabled_cnt;
  logic [3:0]              g3_enabled_cnt;
  // named views of the enable fields, group two
  logic                    pin7_voltage_hi_en;
  logic                    pin7_voltage_lo_en;
  logic                    pin6_cmp0_hi_en;
  logic                    pin6_cmp0_lo_en;
  logic                    pin5_cmp1_hi_en;
  logic                    pin5_cmp1_lo_en;
  logic [4:1]              shared_pin_hi_en;
  logic [4:1]              shared_pin_lo_en;
  logic                    pin0_hi_en;
  logic                    pin0_lo_en;
  // group three
  logic                    timer_a_hi_en;
  logic                    timer_a_lo_en;
  logic                    multichan_timer_hi_en;
  logic                    multichan_timer_lo_en;
  logic [3:0]              portc_pin_hi_en;
  logic [3:0]              portc_pin_lo_en;
  // select fields
  logic                    low_voltage_sel;
  logic                    cmp0_sel;
  logic                    cmp1_sel;
  logic [4:1]              shared_source_sel;
  // encoder inputs rebuilt from the fields
  logic [7:0]              g2_hi_vec;
  logic [7:0]              g2_lo_vec;
  logic [7:0]              g3_hi_vec;
  logic [7:0]              g3_lo_vec;

  // merge a byte write under lane 0 strobe and a mask of writable bits
  function automatic logic [7:0] merge_byte(
    input logic [7:0] old_v,
    input logic [7:0] new_v,
    input logic [7:0] mask,
    input logic       lane
  );
    merge_byte = lane ? ((new_v & mask) | (old_v & ~mask)) : old_v;
  endfunction

  // number of sources enabled at any level, shown in the status word
  function automatic logic [3:0] count_enabled(
    input logic [7:0] hi,
    input logic [7:0] lo
  );
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, hi[i] | lo[i]};
    end
    count_enabled = n;
  endfunction

  assign req.psel    = PSEL;
  assign req.penable = PENABLE;
  assign req.pwrite  = PWRITE;
  assign req.paddr   = PADDR;
  assign req.pwdata  = PWDATA;

  // zero wait states: every access completes in its first access cycle
  assign PREADY = 1'b1;

  always_comb begin
    case (req.paddr)
      ipb_pkg::G2_HIGH_ADDR,
      ipb_pkg::G2_LOW_ADDR,
      ipb_pkg::G3_HIGH_ADDR,
      ipb_pkg::G3_LOW_ADDR,
      ipb_pkg::SEL_ADDR,
      ipb_pkg::STAT_ADDR: addr_ok = 1'b1;
      default:            addr_ok = 1'b0;
    endcase
  end

  // unmapped addresses answer with an error, nothing stored
  assign PSLVERR = req.psel & req.penable & ~addr_ok;
  assign wr_take = req.psel & req.penable & req.pwrite & addr_ok;
  assign rd_take = req.psel & req.penable & ~req.pwrite;

  // one write strobe per stored register; the status word has none,
  // so writes there are taken without effect and without error
  assign wr_g2_high = wr_take && (req.paddr == ipb_pkg::G2_HIGH_ADDR);
  assign wr_g2_low  = wr_take && (req.paddr == ipb_pkg::G2_LOW_ADDR);
  assign wr_g3_high = wr_take && (req.paddr == ipb_pkg::G3_HIGH_ADDR);
  assign wr_g3_low  = wr_take && (req.paddr == ipb_pkg::G3_LOW_ADDR);
  assign wr_sel     = wr_take && (req.paddr == ipb_pkg::SEL_ADDR);

  // group two high register
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      g2_r.high <= ipb_pkg::ENABLE_RST;
    end else if (wr_g2_high) begin
      g2_r.high <= merge_byte(g2_r.high, req.pwdata[7:0], 8'hFF,
                              PSTRB[0]);
    end
  end

  // group two low register
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      g2_r.low <= ipb_pkg::ENABLE_RST;
    end else if (wr_g2_low) begin
      g2_r.low <= merge_byte(g2_r.low, req.pwdata[7:0], 8'hFF,
                             PSTRB[0]);
    end
  end

  // group three high register; reserved bits never leave zero
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      g3_r.high <= ipb_pkg::ENABLE_RST;
    end else if (wr_g3_high) begin
      g3_r.high <= merge_byte(g3_r.high, req.pwdata[7:0],
                              ipb_pkg::G3_WR_MASK, PSTRB[0]);
    end
  end

  // group three low register
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      g3_r.low <= ipb_pkg::ENABLE_RST;
    end else if (wr_g3_low) begin
      g3_r.low <= merge_byte(g3_r.low, req.pwdata[7:0],
                             ipb_pkg::G3_WR_MASK, PSTRB[0]);
    end
  end

  // shared source select
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      shared_source_select_r <= ipb_pkg::SEL_RST;
    end else if (wr_sel) begin
      shared_source_select_r <= merge_byte(shared_source_select_r,
                                           req.pwdata[7:0],
                                           ipb_pkg::SEL_WR_MASK,
                                           PSTRB[0]);
    end
  end

  // read mux; status shows enabled counts of both groups
  always_comb begin
    case (req.paddr)
      ipb_pkg::G2_HIGH_ADDR: rd_byte = g2_r.high;
      ipb_pkg::G2_LOW_ADDR:  rd_byte = g2_r.low;
      ipb_pkg::G3_HIGH_ADDR: rd_byte = g3_r.high;
      ipb_pkg::G3_LOW_ADDR:  rd_byte = g3_r.low;
      ipb_pkg::SEL_ADDR:     rd_byte = shared_source_select_r;
      ipb_pkg::STAT_ADDR:    rd_byte = {g3_enabled_cnt, g2_enabled_cnt};
      default:               rd_byte = 8'h00;
    endcase
  end

  // read data is held in a flop only so it is stable; loaded combinationally
  // into the access cycle would need no flop, but data outputs are flopped,
  // so the word is captured during the setup cycle
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (req.psel && !req.penable && !req.pwrite) begin
      PRDATA <= {24'h00_0000, rd_byte};
    end else if (rd_take) begin
      PRDATA <= 32'h0000_0000;
    end
  end

  // source routing for group two
  always_comb begin
    g2_raw = '0;
    g2_raw[ipb_pkg::G2_PIN7_VOLTAGE] = low_voltage_sel
                                       ? LOW_VOLTAGE_DETECTOR_REQ
                                       : PIN7_REQ;
    g2_raw[ipb_pkg::G2_PIN6_CMP0]    = cmp0_sel
                                       ? CMP0_REQ : PIN6_REQ;
    g2_raw[ipb_pkg::G2_PIN5_CMP1]    = cmp1_sel
                                       ? CMP1_REQ : PIN5_REQ;
    for (int i = ipb_pkg::G2_SHARED_LO; i <= ipb_pkg::G2_SHARED_HI; i++) begin
      // clear picks port A, set picks port D
      g2_raw[i] = shared_source_sel[i] ? PORTD_SHARED_REQ[i]
                                       : PORTA_SHARED_REQ[i];
    end
    g2_raw[ipb_pkg::G2_PIN0] = PIN0_REQ;
  end

  // source routing for group three; reserved positions carry nothing
  always_comb begin
    g3_raw = '0;
    g3_raw[ipb_pkg::G3_TIMER_A]   = TIMER_A_REQ;
    g3_raw[ipb_pkg::G3_MULTICHAN] = MULTICHAN_TIMER_REQ;
    g3_raw[ipb_pkg::G3_PORTC_HI:0] = PORTC_REQ;
  end

  // named field views; positions come from the package
  assign pin7_voltage_hi_en    = g2_r.high[ipb_pkg::G2_PIN7_VOLTAGE];
  assign pin7_voltage_lo_en    = g2_r.low[ipb_pkg::G2_PIN7_VOLTAGE];
  assign pin6_cmp0_hi_en       = g2_r.high[ipb_pkg::G2_PIN6_CMP0];
  assign pin6_cmp0_lo_en       = g2_r.low[ipb_pkg::G2_PIN6_CMP0];
  assign pin5_cmp1_hi_en       = g2_r.high[ipb_pkg::G2_PIN5_CMP1];
  assign pin5_cmp1_lo_en       = g2_r.low[ipb_pkg::G2_PIN5_CMP1];
  assign shared_pin_hi_en      =
    g2_r.high[ipb_pkg::G2_SHARED_HI:ipb_pkg::G2_SHARED_LO];
  assign shared_pin_lo_en      =
    g2_r.low[ipb_pkg::G2_SHARED_HI:ipb_pkg::G2_SHARED_LO];
  assign pin0_hi_en            = g2_r.high[ipb_pkg::G2_PIN0];
  assign pin0_lo_en            = g2_r.low[ipb_pkg::G2_PIN0];
  assign timer_a_hi_en         = g3_r.high[ipb_pkg::G3_TIMER_A];
  assign timer_a_lo_en         = g3_r.low[ipb_pkg::G3_TIMER_A];
  assign multichan_timer_hi_en = g3_r.high[ipb_pkg::G3_MULTICHAN];
  assign multichan_timer_lo_en = g3_r.low[ipb_pkg::G3_MULTICHAN];
  assign portc_pin_hi_en       = g3_r.high[ipb_pkg::G3_PORTC_HI:0];
  assign portc_pin_lo_en       = g3_r.low[ipb_pkg::G3_PORTC_HI:0];

  // select fields; bit 0 has no field, so pin 0 is never switched
  assign low_voltage_sel       =
    shared_source_select_r[ipb_pkg::G2_PIN7_VOLTAGE];
  assign cmp0_sel              =
    shared_source_select_r[ipb_pkg::G2_PIN6_CMP0];
  assign cmp1_sel              =
    shared_source_select_r[ipb_pkg::G2_PIN5_CMP1];
  assign shared_source_sel     =
    shared_source_select_r[ipb_pkg::G2_SHARED_HI:ipb_pkg::G2_SHARED_LO];

  // encoder inputs rebuilt from the fields; reserved group three
  // positions are tied to zero here as well as in the registers
  always_comb begin
    g2_hi_vec = '0;
    g2_lo_vec = '0;
    g2_hi_vec[ipb_pkg::G2_PIN7_VOLTAGE] = pin7_voltage_hi_en;
    g2_lo_vec[ipb_pkg::G2_PIN7_VOLTAGE] = pin7_voltage_lo_en;
    g2_hi_vec[ipb_pkg::G2_PIN6_CMP0]    = pin6_cmp0_hi_en;
    g2_lo_vec[ipb_pkg::G2_PIN6_CMP0]    = pin6_cmp0_lo_en;
    g2_hi_vec[ipb_pkg::G2_PIN5_CMP1]    = pin5_cmp1_hi_en;
    g2_lo_vec[ipb_pkg::G2_PIN5_CMP1]    = pin5_cmp1_lo_en;
    g2_hi_vec[ipb_pkg::G2_SHARED_HI:ipb_pkg::G2_SHARED_LO] = shared_pin_hi_en;
    g2_lo_vec[ipb_pkg::G2_SHARED_HI:ipb_pkg::G2_SHARED_LO] = shared_pin_lo_en;
    g2_hi_vec[ipb_pkg::G2_PIN0]         = pin0_hi_en;
    g2_lo_vec[ipb_pkg::G2_PIN0]         = pin0_lo_en;
  end

  always_comb begin
    g3_hi_vec = '0;
    g3_lo_vec = '0;
    g3_hi_vec[ipb_pkg::G3_TIMER_A]    = timer_a_hi_en;
    g3_lo_vec[ipb_pkg::G3_TIMER_A]    = timer_a_lo_en;
    g3_hi_vec[ipb_pkg::G3_MULTICHAN]  = multichan_timer_hi_en;
    g3_lo_vec[ipb_pkg::G3_MULTICHAN]  = multichan_timer_lo_en;
    g3_hi_vec[ipb_pkg::G3_PORTC_HI:0] = portc_pin_hi_en;
    g3_lo_vec[ipb_pkg::G3_PORTC_HI:0] = portc_pin_lo_en;
  end

  // enabled counts for the status word
  assign g2_enabled_cnt = count_enabled(g2_r.high, g2_r.low);
  assign g3_enabled_cnt = count_enabled(g3_r.high, g3_r.low);

  // levels come straight from the registers, so a write shows next cycle
  ipb_level_encode #(
    .WIDTH (G2_W)
  ) u_group_two (
    .high_en (g2_hi_vec),
    .low_en  (g2_lo_vec),
    .req_in  (g2_raw),
    .level   (REQUEST_GROUP_TWO_LEVEL),
    .req_out (REQUEST_GROUP_TWO)
  );

  ipb_level_encode #(
    .WIDTH (G3_W)
  ) u_group_three (
    .high_en (g3_hi_vec),
    .low_en  (g3_lo_vec),
    .req_in  (g3_raw),
    .level   (REQUEST_GROUP_THREE_LEVEL),
    .req_out (REQUEST_GROUP_THREE)
  );

endmodule

// [rtl/ipb_pkg.sv]
// ipb_pkg: offsets, field layouts, reset values and carrier structs for
// the interrupt priority enable bank.
// assumes an APB master with 32-bit data; one register per aligned word.
package ipb_pkg;

  // printed offsets are not all multiples of four: they are indices
  localparam logic [11:0] G2_HIGH_IDX = 12'hFC7;
  localparam logic [11:0] G2_LOW_IDX  = 12'hFC8;
  localparam logic [11:0] G3_HIGH_IDX = 12'hFCA;
  localparam logic [11:0] G3_LOW_IDX  = 12'hFCB;
  localparam logic [11:0] SEL_IDX     = 12'hFCD;
  localparam logic [11:0] STAT_IDX    = 12'hFCE;

  localparam int ADDR_W = 14;

  // byte address is four times the index
  localparam logic [13:0] G2_HIGH_ADDR = {G2_HIGH_IDX, 2'h0};
  localparam logic [13:0] G2_LOW_ADDR  = {G2_LOW_IDX, 2'h0};
  localparam logic [13:0] G3_HIGH_ADDR = {G3_HIGH_IDX, 2'h0};
  localparam logic [13:0] G3_LOW_ADDR  = {G3_LOW_IDX, 2'h0};
  localparam logic [13:0] SEL_ADDR     = {SEL_IDX, 2'h0};
  localparam logic [13:0] STAT_ADDR    = {STAT_IDX, 2'h0};

  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] SEL_RST    = 8'h00;

  // group three writable bits: 7, 6 and 3..0; bits 5:4 read zero
  localparam logic [7:0] G3_WR_MASK = 8'hCF;
  // select register: bit 0 reserved, reads zero
  localparam logic [7:0] SEL_WR_MASK = 8'hFE;

  // group two bit positions
  localparam int G2_PIN7_VOLTAGE = 7;
  localparam int G2_PIN6_CMP0    = 6;
  localparam int G2_PIN5_CMP1    = 5;
  localparam int G2_SHARED_HI    = 4;
  localparam int G2_SHARED_LO    = 1;
  localparam int G2_PIN0         = 0;

  // group three bit positions
  localparam int G3_TIMER_A     = 7;
  localparam int G3_MULTICHAN   = 6;
  localparam int G3_PORTC_HI    = 3;

  localparam logic [1:0] LVL_DISABLED = 2'h0;
  localparam logic [1:0] LVL_LOW      = 2'h1;
  localparam logic [1:0] LVL_NOMINAL  = 2'h2;
  localparam logic [1:0] LVL_HIGH     = 2'h3;

  typedef logic [1:0] ipb_level_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [13:0] paddr;
    logic [31:0] pwdata;
  } ipb_apb_req_s;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } ipb_enable_pair_s;

endpackage

// [rtl/ipb_level_encode.sv]
// ipb_level_encode: turns one group's high/low enable pair into a
// two-bit priority per source and gates raw requests by it.
// assumes requests are already latched and synchronous to the clock.
`timescale 1ns/1ps
module ipb_level_encode #(
  parameter int WIDTH = 8
) (
  // enables
  input  wire logic [WIDTH-1:0]   high_en,
  input  wire logic [WIDTH-1:0]   low_en,
  // requests
  input  wire logic [WIDTH-1:0]   req_in,
  // results
  output logic      [2*WIDTH-1:0] level,
  output logic      [WIDTH-1:0]   req_out
);

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      // high bit is the msb of the level
      level[2*i +: 2] = {high_en[i], low_en[i]};
      // disabled sources never reach the arbiter
      req_out[i]      = req_in[i] & (high_en[i] | low_en[i]);
    end
  end

endmodule

// [tb/ipb_arb_model.sv]
// ipb_arb_model: far-side arbiter stand-in, picks the top pending level.
// assumes group-two levels and gated requests straight from the bank.
`timescale 1ns/1ps
module ipb_arb_model (
  // from bank
  input  wire logic [15:0] lvl,
  input  wire logic [7:0]  req,
  // winner
  output logic      [1:0]  top
);
  always_comb begin
    top = 2'h0;
    for (int i = 0; i < 8; i++) begin
      if (req[i] && lvl[2*i+:2] > top) begin
        top = lvl[2*i+:2];
      end
    end
  end
endmodule

// [tb/ipb_bank_chk.sv]
// ipb_bank_chk: port-level checks of the enable bank.
// assumes bound into ipb_bank with its default widths.
`timescale 1ns/1ps
module ipb_bank_chk (
  // clock, reset
  input wire logic        CORE_CLK,
  input wire logic        RST,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [13:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0]  PSTRB,
  // sources and results
  input wire logic        PIN0_REQ,
  input wire logic [4:1]  PORTA_SHARED_REQ,
  input wire logic [4:1]  PORTD_SHARED_REQ,
  input wire logic [15:0] REQUEST_GROUP_TWO_LEVEL,
  input wire logic [15:0] REQUEST_GROUP_THREE_LEVEL,
  input wire logic [7:0]  REQUEST_GROUP_TWO,
  input wire logic [7:0]  REQUEST_GROUP_THREE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic [7:0] g2h, g2l, g3h, g3l, wd;
  logic       wr;
  assign wd = PWDATA[7:0];
  assign wr = PSEL && PENABLE && PWRITE && PSTRB[0];
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      g2h[i] = REQUEST_GROUP_TWO_LEVEL[2*i+1];
      g2l[i] = REQUEST_GROUP_TWO_LEVEL[2*i];
      g3h[i] = REQUEST_GROUP_THREE_LEVEL[2*i+1];
      g3l[i] = REQUEST_GROUP_THREE_LEVEL[2*i];
    end
  end
  AST_G2H: assert property (wr && PADDR == ipb_pkg::G2_HIGH_ADDR
    |=> g2h == $past(wd)) else $error("group two high not stored");
  AST_G2L: assert property (wr && PADDR == ipb_pkg::G2_LOW_ADDR
    |=> g2l == $past(wd)) else $error("group two low not stored");
  AST_G3H: assert property (wr && PADDR == ipb_pkg::G3_HIGH_ADDR
    |=> g3h == ($past(wd) & 8'hCF)) else $error("group three high bad");
  AST_G3L: assert property (wr && PADDR == ipb_pkg::G3_LOW_ADDR
    |=> g3l == ($past(wd) & 8'hCF)) else $error("group three low bad");
  AST_HOLD: assert property (!wr |=> $stable(REQUEST_GROUP_TWO_LEVEL)
    && $stable(REQUEST_GROUP_THREE_LEVEL)) else $error("level moved");
  AST_G2GATE: assert property ((REQUEST_GROUP_TWO & ~(g2h | g2l)) == 8'h00)
    else $error("disabled group two request shown");
  AST_G3GATE: assert property ((REQUEST_GROUP_THREE & ~(g3h | g3l)) == 8'h00)
    else $error("disabled group three request shown");
  AST_RSV: assert property (g3h[5:4] == 2'h0 && g3l[5:4] == 2'h0
    && REQUEST_GROUP_THREE[5:4] == 2'h0) else $error("reserved bits set");
  AST_PIN0: assert property (REQUEST_GROUP_TWO[0]
    == (PIN0_REQ && (g2h[0] || g2l[0]))) else $error("pin 0 routing");
  AST_SHARED: assert property (
    PORTA_SHARED_REQ == PORTD_SHARED_REQ |-> REQUEST_GROUP_TWO[4:1]
    == (PORTA_SHARED_REQ & (g2h[4:1] | g2l[4:1])))
    else $error("shared request routing");
endmodule

// [tb/ipb_bank_tb.sv]
// ipb_bank_tb: register rows, encoding, routing, refusal and reset tests.
// assumes a zero-or-more wait-state apb slave; drives all sources.
`timescale 1ns/1ps
module ipb_bank_tb;
  typedef struct {logic [13:0] a; logic [7:0] d; logic [7:0] e;} ipb_row_s;
  ipb_row_s    rows [4];
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [13:0] padr = 14'h0000;
  logic [31:0] pwd = 32'h0000_0000;
  logic [3:0]  pstb = 4'h0;
  logic [20:0] src = 21'h00_0000;
  logic [31:0] prd, rd;
  logic        prdy, perr, er;
  logic [15:0] l2, l3;
  logic [7:0]  r2, r3;
  logic [1:0]  top;
  int          error_cnt = 0;
  int          samples_checked = 0;
  always #4 clk = ~clk;
  ipb_bank i_dut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PSTRB(pstb), .PRDATA(prd),
    .PREADY(prdy), .PSLVERR(perr), .PIN0_REQ(src[0]),
    .PORTA_SHARED_REQ(src[4:1]), .PORTD_SHARED_REQ(src[8:5]),
    .PIN5_REQ(src[9]), .CMP1_REQ(src[10]), .PIN6_REQ(src[11]),
    .CMP0_REQ(src[12]), .PIN7_REQ(src[13]),
    .LOW_VOLTAGE_DETECTOR_REQ(src[14]), .TIMER_A_REQ(src[15]),
    .MULTICHAN_TIMER_REQ(src[16]), .PORTC_REQ(src[20:17]),
    .REQUEST_GROUP_TWO_LEVEL(l2), .REQUEST_GROUP_THREE_LEVEL(l3),
    .REQUEST_GROUP_TWO(r2), .REQUEST_GROUP_THREE(r3));
  ipb_arb_model i_arb (.lvl(l2), .req(r2), .top(top));
  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // called just after a rising edge; returns one idle edge later
  task automatic apb(input logic w, input logic [13:0] a, input logic [7:0] d,
                     input logic s, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= {24'h00_0000, d};
    pstb <= {3'h0, s & w};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      print_verdict();
    end
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] enc(input logic [7:0] h, input logic [7:0] l);
    enc = 32'h0000_0000;
    for (int i = 0; i < 8; i++) enc[2*i+:2] = {h[i], l[i]};
  endfunction
  initial begin
    rows[0] = '{ipb_pkg::G2_HIGH_ADDR, 8'hA5, 8'hA5};
    rows[1] = '{ipb_pkg::G2_LOW_ADDR, 8'h3C, 8'h3C};
    rows[2] = '{ipb_pkg::G3_HIGH_ADDR, 8'hFF, 8'hCF};
    rows[3] = '{ipb_pkg::G3_LOW_ADDR, 8'h30, 8'h00};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[k]) begin
      apb(1'b1, rows[k].a, rows[k].d, 1'b1, rd, er);
      apb(1'b0, rows[k].a, 8'h00, 1'b1, rd, er);
      chk(rd, {24'h00_0000, rows[k].e});
      chk({31'h0, er}, 32'h0000_0000);
    end
    chk({16'h0000, l2}, enc(8'hA5, 8'h3C));
    chk({16'h0000, l3}, enc(8'hCF, 8'h00));
    apb(1'b0, ipb_pkg::STAT_ADDR, 8'h00, 1'b0, rd, er);
    chk(rd, 32'h0000_0066);
    // unmapped write is refused and leaves state alone
    apb(1'b1, 14'h0008, 8'hFF, 1'b1, rd, er);
    chk({31'h0, er}, 32'h0000_0001);
    chk({l3, l2}, {enc(8'hCF, 8'h00), 16'h0000} | enc(8'hA5, 8'h3C));
    // unmapped read is refused
    apb(1'b0, 14'h0004, 8'h00, 1'b1, rd, er);
    chk({rd[30:0], er}, 32'h0000_0001);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({l3, l2}, 32'h0000_0000);
    foreach (rows[k]) begin
      apb(1'b0, rows[k].a, 8'h00, 1'b1, rd, er);
      chk(rd, 32'h0000_0000);
    end
    // port A side first, then the alternates
    apb(1'b1, ipb_pkg::G2_HIGH_ADDR, 8'hFF, 1'b1, rd, er);
    src <= 21'h00_2A1F;
    @(posedge clk);
    chk({24'h00_0000, r2}, 32'h0000_00FF);
    chk({30'h0, top}, {30'h0, ipb_pkg::LVL_NOMINAL});
    apb(1'b1, ipb_pkg::SEL_ADDR, 8'hFF, 1'b1, rd, er);
    chk({24'h00_0000, r2}, 32'h0000_0001);
    apb(1'b0, ipb_pkg::SEL_ADDR, 8'h00, 1'b0, rd, er);
    chk(rd, 32'h0000_00FE);
    src <= 21'h00_55E0;
    @(posedge clk);
    chk({24'h00_0000, r2}, 32'h0000_00FE);
    src <= 21'h00_01FE;
    @(posedge clk);
    chk({24'h00_0000, r2}, 32'h0000_001E);
    // strobe low write leaves state alone
    apb(1'b1, ipb_pkg::G2_HIGH_ADDR, 8'h00, 1'b0, rd, er);
    chk({16'h0000, l2}, 32'h0000_AAAA);
    apb(1'b1, ipb_pkg::G2_HIGH_ADDR, 8'h00, 1'b1, rd, er);
    chk({24'h00_0000, r2}, 32'h0000_0000);
    apb(1'b1, ipb_pkg::G3_HIGH_ADDR, 8'h40, 1'b1, rd, er);
    src <= 21'h1F_8000;
    @(posedge clk);
    chk({24'h00_0000, r3}, 32'h0000_0040);
    chk({16'h0000, l3}, 32'h0000_2000);
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
endmodule
bind ipb_bank ipb_bank_chk i_chk (.CORE_CLK, .RST, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .PSTRB, .PIN0_REQ, .PORTA_SHARED_REQ, .PORTD_SHARED_REQ,
  .REQUEST_GROUP_TWO_LEVEL, .REQUEST_GROUP_THREE_LEVEL, .REQUEST_GROUP_TWO,
  .REQUEST_GROUP_THREE);
